// [core/spmc_pkg.sv]
package spmc_pkg;
  // control register field positions
  localparam int CTL_SLEEP_EN_BIT = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_BOD_OFF_BIT = 4;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // peripheral gate register field positions
  localparam int GATE_CONVERTER = 0;
  localparam int GATE_TIMER_ZERO = 1;
  localparam int GATE_TIMER_ONE = 2;
  localparam int GATE_SPI = 3;
  localparam int GATE_TWOWIRE = 4;
  localparam logic [4:0] GATE_RESET = 5'h00;
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NOISE = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_STANDBY = 3'h4;
  // wake timing
  localparam int WAKE_HALT_CYCLES = 4;
  localparam int OSC_START_CYCLES = 6;
  localparam int CLK_MHZ = 125;
  localparam int BOD_SETTLE_US = 60;
  localparam int BOD_SETTLE_CYCLES = BOD_SETTLE_US * CLK_MHZ;
  localparam int PROTECT_WINDOW_CYCLES = 4;
  // controller states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_START = 4'h4,
    ST_HALT = 4'h8
  } spmc_state_type;
endpackage

// [core/spmc_counter.sv]
// loadable down counter, done while zero
module spmc_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // next count
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = loadValue;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  // count register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clkEn) begin
      count <= next_count;
    end
  end

  assign done = (count == '0);
endmodule // spmc_counter

// [core/sleep_power_ctrl.sv]
// Behaviour
// - idle stops core and flash clocks
// - noise mode also stops io clock
// - power-down stops oscillator and all clocks
// - power-down wakes on four async sources
// - standby like power-down, oscillator kept
// - deep modes: level irq0, address match, pin change, watchdog only
// - wake halts core four cycles plus startup
// - register file and sram kept intact
// - reset while asleep restarts from vector
// - idle or noise mode starts conversion
// - brown-out off during sleep, on at wake
// - wake delayed sixty microseconds after bod-off
// - bod-off bit resets zero, deep modes only
// - bod-off set only by protected sequence
// - gated peripheral frozen, registers inaccessible
// - clearing gate bit resumes peripheral clock
// - peripheral gating meaningful in active, idle
// - comparator disabled in power-down
// - input buffers off when io clock stops
// - watchdog stays enabled; fused bod too, except bod-off deep sleep
// - converter restart needs extended conversion
// - control bits: enable 0, mode 3:1, bod 4
// - bod-off clears on wake or plain zero
// - gate bits: twi4 spi3 t1 2 t0 1 adc0
module sleep_power_ctrl #(
  parameter int BOD_SETTLE = spmc_pkg::BOD_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic ctlWrite,
  input wire logic [7:0] ctlWriteData,
  output logic [7:0] coreControlReg,
  input wire logic gateWrite,
  input wire logic [4:0] gateWriteData,
  output logic [4:0] peripheralClockGateReg,
  input wire logic protectUnlock,
  input wire logic sleepInstr,
  input wire logic irqPending,
  input wire logic externalIrqZero,
  input wire logic extIrqLevelMode,
  input wire logic pinChangeIrq,
  input wire logic watchdogIrq,
  input wire logic twoWireAddrMatch,
  input wire logic converterEnabled,
  input wire logic brownoutFuseEnabled,
  input wire logic watchdogEnabled,
  output logic coreClkEn,
  output logic flashClkEn,
  output logic ioClkEn,
  output logic converterClkEn,
  output logic oscillatorEn,
  output logic [4:0] peripheralClkEn,
  output logic coreStall,
  output logic asleep,
  output logic brownoutDetectorEn,
  output logic watchdogRun,
  output logic comparatorDisable,
  output logic inputBufferDisable,
  output logic conversionStart,
  output logic extendedConversion,
  output logic wakeIrqTaken
);
  spmc_pkg::spmc_state_type state;
  spmc_pkg::spmc_state_type next_state;
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic [4:0] gate;
  logic [4:0] next_gate;
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic bodOff;
  logic next_bodOff;
  logic [2:0] protectCnt;
  logic [2:0] next_protectCnt;
  logic convStart;
  logic next_convStart;
  logic convWasOn;
  logic convNeedExt;
  logic next_convNeedExt;
  logic wakeEvent;
  logic validSleep;
  logic deepMode;
  logic cntLoad;
  logic [15:0] cntValue;
  logic cntDone;
  logic [2:0] selMode;

  assign selMode = ctl[spmc_pkg::CTL_MODE_HI:spmc_pkg::CTL_MODE_LO];
  assign validSleep = ctl[spmc_pkg::CTL_SLEEP_EN_BIT]
    && (selMode == spmc_pkg::MODE_IDLE || selMode == spmc_pkg::MODE_NOISE
    || selMode == spmc_pkg::MODE_PDOWN || selMode == spmc_pkg::MODE_STANDBY);
  assign deepMode = (mode == spmc_pkg::MODE_PDOWN) || (mode == spmc_pkg::MODE_STANDBY);

  // wake source qualification per mode
  always_comb begin
    // level irq0, address match, pin change and watchdog only
    wakeEvent = watchdogIrq || pinChangeIrq || twoWireAddrMatch
      || (externalIrqZero && extIrqLevelMode);
    if (mode == spmc_pkg::MODE_IDLE) begin
      wakeEvent = irqPending;
    end
  end

  // sleep and wake sequencing
  always_comb begin
    next_state = state;
    next_mode = mode;
    cntLoad = 1'b0;
    cntValue = 16'h0000;
    case (state)
      spmc_pkg::ST_RUN: begin
        if (sleepInstr && validSleep) begin
          next_state = spmc_pkg::ST_SLEEP;
          next_mode = selMode;
        end
      end
      spmc_pkg::ST_SLEEP: begin
        if (wakeEvent) begin
          next_state = spmc_pkg::ST_START;
          cntLoad = 1'b1;
          // long settle after bod was off
          if (bodOff) begin
            cntValue = 16'(BOD_SETTLE);
          end else if (mode == spmc_pkg::MODE_PDOWN) begin
            cntValue = 16'(spmc_pkg::OSC_START_CYCLES);
          end
        end
      end
      spmc_pkg::ST_START: begin
        if (cntDone) begin
          next_state = spmc_pkg::ST_HALT;
          cntLoad = 1'b1;
          cntValue = 16'(spmc_pkg::WAKE_HALT_CYCLES - 1);
        end
      end
      spmc_pkg::ST_HALT: begin
        if (cntDone) begin
          next_state = spmc_pkg::ST_RUN;
        end
      end
      default: next_state = spmc_pkg::ST_RUN;
    endcase
  end

  // wake delay counter
  spmc_counter #(
    .WIDTH(16)
  ) u_delay (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .load(cntLoad),
    .loadValue(cntValue),
    .done(cntDone)
  );

  // control and gate registers
  always_comb begin
    next_ctl = ctl;
    next_gate = gate;
    next_bodOff = bodOff;
    next_protectCnt = (protectCnt != 3'h0) ? protectCnt - 3'h1 : 3'h0;
    if (protectUnlock) begin
      next_protectCnt = 3'(spmc_pkg::PROTECT_WINDOW_CYCLES);
    end
    if (ctlWrite) begin
      next_ctl = ctlWriteData & 8'h1f;
      if (ctlWriteData[spmc_pkg::CTL_BOD_OFF_BIT] && protectCnt != 3'h0) begin
        next_ctl[spmc_pkg::CTL_BOD_OFF_BIT] = 1'b1;
      end else if (!ctlWriteData[spmc_pkg::CTL_BOD_OFF_BIT]) begin
        next_ctl[spmc_pkg::CTL_BOD_OFF_BIT] = 1'b0;
      end else begin
        next_ctl[spmc_pkg::CTL_BOD_OFF_BIT] = ctl[spmc_pkg::CTL_BOD_OFF_BIT];
      end
    end
    if (gateWrite) begin
      next_gate = gateWriteData;
    end
    // bod off at deep sleep entry
    if (state == spmc_pkg::ST_RUN && next_state == spmc_pkg::ST_SLEEP) begin
      next_bodOff = ctl[spmc_pkg::CTL_BOD_OFF_BIT]
        && (selMode == spmc_pkg::MODE_PDOWN || selMode == spmc_pkg::MODE_STANDBY);
    end
    if (state == spmc_pkg::ST_SLEEP && wakeEvent) begin
      next_ctl[spmc_pkg::CTL_BOD_OFF_BIT] = 1'b0;
    end
    if (state == spmc_pkg::ST_HALT && cntDone) begin
      next_bodOff = 1'b0;
    end
  end

  // converter conversion tracking
  always_comb begin
    // entering idle or noise starts conversion
    next_convStart = state == spmc_pkg::ST_RUN && next_state == spmc_pkg::ST_SLEEP
      && converterEnabled
      && (selMode == spmc_pkg::MODE_IDLE || selMode == spmc_pkg::MODE_NOISE);
    // off then on needs extended conversion
    next_convNeedExt = convNeedExt;
    if (!convWasOn && converterEnabled) begin
      next_convNeedExt = 1'b1;
    end else if (convStart) begin
      next_convNeedExt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= spmc_pkg::ST_RUN;
      mode <= spmc_pkg::MODE_IDLE;
      ctl <= spmc_pkg::CTL_RESET;
      gate <= spmc_pkg::GATE_RESET;
      bodOff <= 1'b0;
      protectCnt <= 3'h0;
      convStart <= 1'b0;
      convWasOn <= 1'b0;
      convNeedExt <= 1'b1;
    end else if (clkEn) begin
      state <= next_state;
      mode <= next_mode;
      ctl <= next_ctl;
      gate <= next_gate;
      bodOff <= next_bodOff;
      protectCnt <= next_protectCnt;
      convStart <= next_convStart;
      convWasOn <= converterEnabled;
      convNeedExt <= next_convNeedExt;
    end
  end

  assign asleep = (state == spmc_pkg::ST_SLEEP);
  // no storage touched, core only stalled
  assign coreStall = (state != spmc_pkg::ST_RUN);
  assign coreClkEn = !asleep;
  assign flashClkEn = !asleep;
  assign ioClkEn = !asleep || mode == spmc_pkg::MODE_IDLE;
  assign converterClkEn = !asleep || mode == spmc_pkg::MODE_IDLE || mode == spmc_pkg::MODE_NOISE;
  assign oscillatorEn = !(asleep && mode == spmc_pkg::MODE_PDOWN);
  // gating on top of sleep gating
  always_comb begin
    peripheralClkEn = ~gate & {5{ioClkEn}};
    peripheralClkEn[spmc_pkg::GATE_CONVERTER] = !gate[spmc_pkg::GATE_CONVERTER] && converterClkEn;
  end
  assign brownoutDetectorEn = brownoutFuseEnabled && !(asleep && bodOff && deepMode);
  assign watchdogRun = watchdogEnabled;
  assign comparatorDisable = asleep && mode == spmc_pkg::MODE_PDOWN;
  // input buffers off without io clock
  assign inputBufferDisable = !ioClkEn;
  assign conversionStart = convStart;
  assign extendedConversion = convNeedExt;
  assign wakeIrqTaken = (state == spmc_pkg::ST_HALT) && cntDone;
  assign coreControlReg = ctl;
  assign peripheralClockGateReg = gate;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wake_idle;
    asleep && clkEn && wakeEvent && mode == spmc_pkg::MODE_IDLE && !bodOff;
  endsequence

  a_wake_halt_len: assert property (
    s_wake_idle ##1 clkEn [*5] |-> wakeIrqTaken)
    else $error("wake halt length wrong");
  a_reserved_noop: assert property (
    state == spmc_pkg::ST_RUN && sleepInstr && clkEn && !validSleep |=> !asleep)
    else $error("reserved sleep entered");
  a_idle_clocks: assert property (
    asleep && mode == spmc_pkg::MODE_IDLE |-> !coreClkEn && ioClkEn && converterClkEn)
    else $error("idle clock gating wrong");
  a_noise_clocks: assert property (
    asleep && mode == spmc_pkg::MODE_NOISE |-> !ioClkEn && converterClkEn && inputBufferDisable)
    else $error("noise clock gating wrong");
  a_pdown_osc: assert property (
    asleep && mode == spmc_pkg::MODE_PDOWN |-> !oscillatorEn && comparatorDisable)
    else $error("power-down oscillator on");
  a_standby_osc: assert property (
    asleep && mode == spmc_pkg::MODE_STANDBY |-> oscillatorEn && !converterClkEn)
    else $error("standby oscillator off");
  a_bod_protect: assert property (
    $rose(ctl[spmc_pkg::CTL_BOD_OFF_BIT]) |-> $past(protectCnt) != 3'h0)
    else $error("bod-off set unprotected");
  a_bod_wake_clear: assert property (
    asleep && wakeEvent && clkEn |=> !ctl[spmc_pkg::CTL_BOD_OFF_BIT])
    else $error("bod-off not cleared on wake");
  a_conv_start: assert property (
    state == spmc_pkg::ST_RUN && sleepInstr && validSleep && clkEn && converterEnabled
    && selMode == spmc_pkg::MODE_NOISE |=> conversionStart)
    else $error("no conversion on noise entry");
endmodule // sleep_power_ctrl

// [tb/spmc_core_model.sv]
// core side: control writes, unlock signature, sleep instruction
module spmc_core_model (
  input wire logic clk,
  output logic ctlWrite,
  output logic [7:0] ctlWriteData,
  output logic gateWrite,
  output logic [4:0] gateWriteData,
  output logic protectUnlock,
  output logic sleepInstr
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle values
  initial begin
    {ctlWrite, gateWrite, protectUnlock, sleepInstr} = 4'h0;
    ctlWriteData = 8'h00;
    gateWriteData = 5'h00;
  end
  // one-cycle control write, data scrambled once released
  task automatic ctl(input logic [7:0] d);
    @(negedge clk);
    ctlWrite = 1'b1;
    ctlWriteData = d;
    @(negedge clk);
    ctlWrite = 1'b0;
    ctlWriteData = ~d;
  endtask
  // one-cycle peripheral gate write
  task automatic gate(input logic [4:0] d);
    @(negedge clk);
    gateWrite = 1'b1;
    gateWriteData = d;
    @(negedge clk);
    gateWrite = 1'b0;
    gateWriteData = ~d;
  endtask
  task automatic unlock();
    @(negedge clk);
    protectUnlock = 1'b1;
    @(negedge clk);
    protectUnlock = 1'b0;
  endtask
  task automatic sleep_cmd();
    @(negedge clk);
    sleepInstr = 1'b1;
    @(negedge clk);
    sleepInstr = 1'b0;
  endtask
endmodule // spmc_core_model

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  logic clk, rst_n, converterEnabled, extIrqLevelMode;
  logic clkEn, brownoutFuseEnabled, watchdogEnabled;
  logic seenConv = 1'b0;
  logic ctlWrite, gateWrite, protectUnlock, sleepInstr;
  logic [7:0] ctlWriteData, coreControlReg;
  logic [4:0] gateWriteData, peripheralClockGateReg, peripheralClkEn, wakeVec;
  logic irqPending, externalIrqZero, pinChangeIrq, watchdogIrq, twoWireAddrMatch;
  logic coreClkEn, flashClkEn, ioClkEn, converterClkEn, oscillatorEn, coreStall, asleep;
  logic brownoutDetectorEn, watchdogRun, comparatorDisable, inputBufferDisable;
  logic conversionStart, extendedConversion, wakeIrqTaken;
  logic [23:0] r;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // rows: enable, mode, wake source, wake latency, expected clock vector
  logic [23:0] rows [10] = '{{1'b1, 3'h0, 5'h02, 8'h05, 7'h4e}, {1'b1, 3'h1, 5'h08, 8'h05, 7'h47},
    {1'b1, 3'h2, 5'h04, 8'h0b, 7'h41}, {1'b1, 3'h2, 5'h01, 8'h0b, 7'h41},
    {1'b1, 3'h4, 5'h10, 8'h05, 7'h43}, {1'b1, 3'h3, 5'h00, 8'h00, 7'h3e},
    {1'b1, 3'h5, 5'h00, 8'h00, 7'h3e}, {1'b1, 3'h6, 5'h00, 8'h00, 7'h3e},
    {1'b1, 3'h7, 5'h00, 8'h00, 7'h3e}, {1'b0, 3'h2, 5'h00, 8'h00, 7'h3e}};
  assign {twoWireAddrMatch, externalIrqZero, pinChangeIrq, irqPending, watchdogIrq} = wakeVec;
  spmc_core_model i_spmc_core_model (.clk(clk), .ctlWrite(ctlWrite), .ctlWriteData(ctlWriteData),
    .gateWrite(gateWrite), .gateWriteData(gateWriteData), .protectUnlock(protectUnlock),
    .sleepInstr(sleepInstr));
  sleep_power_ctrl #(.BOD_SETTLE(SETTLE)) i_sleep_power_ctrl (.clk(clk), .rst_n(rst_n),
    .clkEn(clkEn), .ctlWrite(ctlWrite), .ctlWriteData(ctlWriteData),
    .coreControlReg(coreControlReg), .gateWrite(gateWrite), .gateWriteData(gateWriteData),
    .peripheralClockGateReg(peripheralClockGateReg), .protectUnlock(protectUnlock),
    .sleepInstr(sleepInstr), .irqPending(irqPending), .externalIrqZero(externalIrqZero),
    .extIrqLevelMode(extIrqLevelMode), .pinChangeIrq(pinChangeIrq), .watchdogIrq(watchdogIrq),
    .twoWireAddrMatch(twoWireAddrMatch), .converterEnabled(converterEnabled),
    .brownoutFuseEnabled(brownoutFuseEnabled), .watchdogEnabled(watchdogEnabled),
    .coreClkEn(coreClkEn),
    .flashClkEn(flashClkEn), .ioClkEn(ioClkEn), .converterClkEn(converterClkEn),
    .oscillatorEn(oscillatorEn), .peripheralClkEn(peripheralClkEn), .coreStall(coreStall),
    .asleep(asleep), .brownoutDetectorEn(brownoutDetectorEn), .watchdogRun(watchdogRun),
    .comparatorDisable(comparatorDisable), .inputBufferDisable(inputBufferDisable),
    .conversionStart(conversionStart), .extendedConversion(extendedConversion),
    .wakeIrqTaken(wakeIrqTaken));
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard and conversion pulse catcher, sampled mid-cycle
  always @(negedge clk) begin
    cycles++;
    if (conversionStart === 1'b1) seenConv <= 1'b1;
    if (cycles == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // reset held twelve cycles, outputs checked while held
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    check({peripheralClockGateReg, coreControlReg}, 16'h0000);
    check({coreClkEn, ioClkEn, oscillatorEn, asleep, coreStall, extendedConversion}, 6'h39);
    rst_n = 1'b1;
  endtask
  task automatic go_sleep(input logic [7:0] c);
    i_spmc_core_model.ctl(c);
    i_spmc_core_model.sleep_cmd();
    @(negedge clk);
  endtask
  // count cycles from wake source to the taken pulse
  task automatic wait_wake(input logic [7:0] lat);
    logic [7:0] n;
    n = 8'h00;
    do begin
      @(negedge clk);
      n++;
    end while (wakeIrqTaken !== 1'b1 && n < 8'h60);
    check(n, lat);
    @(negedge clk);
    check({asleep, coreStall}, 2'h0);
    wakeVec = 5'h00;
  endtask
  initial begin
    clkEn = 1'b1;
    brownoutFuseEnabled = 1'b1;
    watchdogEnabled = 1'b1;
    converterEnabled = 1'b1;
    extIrqLevelMode = 1'b1;
    wakeVec = 5'h00;
    do_reset();
    i_spmc_core_model.gate(5'h15);
    check({peripheralClockGateReg, peripheralClkEn}, 10'h2aa);
    i_spmc_core_model.gate(5'h00);
    check(peripheralClkEn, 5'h1f);
    // mode table
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      go_sleep({4'h0, r[22:20], r[23]});
      check({asleep, coreClkEn, flashClkEn, ioClkEn, converterClkEn, oscillatorEn,
        inputBufferDisable}, r[6:0]);
      if (r[14:7] != 8'h00) begin
        wakeVec = r[19:15];
        wait_wake(r[14:7]);
      end
    end
    check({seenConv, extendedConversion}, 2'h2);
    // deep mode ignores edge irq0 and generic irqs
    go_sleep(8'h05);
    extIrqLevelMode = 1'b0;
    wakeVec = 5'h0a;
    repeat (5) @(negedge clk);
    check({asleep, comparatorDisable, watchdogRun, brownoutDetectorEn}, 4'hf);
    check(peripheralClkEn, 5'h00);
    extIrqLevelMode = 1'b1;
    wait_wake(8'h0b);
    // protected brown-out disable
    i_spmc_core_model.ctl(8'h10);
    check(coreControlReg, 8'h00);
    // write one cycle past the window is refused
    i_spmc_core_model.unlock();
    repeat (3) @(negedge clk);
    i_spmc_core_model.ctl(8'h10);
    check(coreControlReg, 8'h00);
    i_spmc_core_model.unlock();
    i_spmc_core_model.ctl(8'h19);
    check(coreControlReg, 8'h19);
    i_spmc_core_model.ctl(8'h09);
    check(coreControlReg, 8'h09);
    i_spmc_core_model.unlock();
    go_sleep(8'h19);
    check({brownoutDetectorEn, watchdogRun}, 2'h1);
    wakeVec = 5'h01;
    wait_wake(8'h05 + SETTLE[7:0]);
    check({brownoutDetectorEn, coreControlReg[4]}, 2'h2);
    // converter off and on again
    converterEnabled = 1'b0;
    @(negedge clk);
    converterEnabled = 1'b1;
    repeat (2) @(negedge clk);
    check(extendedConversion, 1'b1);
    // reset while asleep
    go_sleep(8'h05);
    do_reset();
    @(negedge clk);
    check({asleep, coreClkEn}, 2'h1);
    // fuse inputs low, then state frozen while clock enable low
    brownoutFuseEnabled = 1'b0;
    watchdogEnabled = 1'b0;
    i_spmc_core_model.ctl(8'h09);
    check({coreControlReg, brownoutDetectorEn, watchdogRun}, 10'h024);
    clkEn = 1'b0;
    i_spmc_core_model.sleep_cmd();
    check({asleep, coreStall, coreClkEn}, 3'h1);
    i_spmc_core_model.ctl(8'h00);
    check(coreControlReg, 8'h09);
    clkEn = 1'b1;
    end_sim();
  end
endmodule // testbench
